// *** hdl/keypad_pkg.sv ***
package keypad_pkg;

    // --------------------------------------------------------------
    // geometry
    // --------------------------------------------------------------
    localparam int NUM_ROWS = 6;
    localparam int NUM_COLS = 5;

    // --------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------
    localparam int            ADDR_W       = 12;
    localparam logic [7:0]    DRIVE_IDX    = 8'hd1;
    localparam logic [7:0]    SENSE_IDX    = 8'hd2;
    localparam logic [7:0]    TIMING_IDX   = 8'hd3;
    localparam logic [7:0]    STATUS_IDX   = 8'hd4;
    localparam logic [7:0]    ORDER_LO_IDX = 8'hd5;
    localparam logic [7:0]    ORDER_HI_IDX = 8'hd6;
    localparam logic [7:0]    SIZE_IDX     = 8'hd7;
    localparam logic [7:0]    CLKCTL_IDX   = 8'hd8;

    // --------------------------------------------------------------
    // values after reset
    // --------------------------------------------------------------
    localparam logic [4:0]    DRIVE_RST    = 5'h1f;
    localparam logic [5:0]    SENSE_RST    = 6'h3f;
    localparam logic [7:0]    TIMING_RST   = 8'h00;
    localparam logic [2:0]    STATUS_RST   = 3'h0;
    localparam logic [7:0]    ORDER_LO_RST = 8'h08;
    localparam logic [8:0]    ORDER_HI_RST = 9'h11a;
    localparam logic [7:0]    SIZE_RST     = 8'h65;
    localparam logic [7:0]    CLKCTL_RST   = 8'h00;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int ST_IEN_BIT    = 0;
    localparam int ST_FLAG_BIT   = 1;
    localparam int ST_SCEN_BIT   = 2;
    localparam int CLK_SLOW_BIT  = 3;
    localparam int CLK_KEYPAD_ENABLE_BIT  = 6;
    localparam int SCAN_TIME_FIELD_LSB    = 0;
    localparam int DEBOUNCE_FIELD_LSB    = 2;
    localparam int SIZE_COLS_LSB = 0;
    localparam int SIZE_ROWS_LSB = 4;
    localparam int SLOT_W        = 3;

    // --------------------------------------------------------------
    // timing, counted in 1 ms ticks
    // --------------------------------------------------------------
    localparam int         TICK_MS        = 1;
    localparam int         DEB_UNIT_MS    = 4;
    localparam logic [6:0] DEB_ZERO_UNITS = 7'd64;
    localparam logic [8:0] SCAN_ZERO_MS   = 9'd4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEB_PRESS,
        ST_SCAN,
        ST_WAIT_REL,
        ST_DEB_REL
    } scan_state_e;

endpackage

// *** hdl/row_sync.sv ***
module row_sync (
    input  wire logic                           clk_i,
    input  wire logic                           reset_i,
    input  wire logic                           ce_i,
    input  wire logic [keypad_pkg::NUM_ROWS-1:0] row_i,
    output logic      [keypad_pkg::NUM_ROWS-1:0] row_o
);
    import keypad_pkg::*;

    typedef struct packed {
        logic [NUM_ROWS-1:0] meta;
        logic [NUM_ROWS-1:0] stable;
    } sync_s;

    sync_s q;
    sync_s d;

    // rows idle high through pull-ups
    always_comb
    begin
        d        = q;
        d.meta   = row_i;
        d.stable = q.meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            q <= '{meta: SENSE_RST, stable: SENSE_RST};
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    assign row_o = q.stable;

endmodule

// *** hdl/keypad_timer.sv ***
module keypad_timer (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    input  wire logic       restart_i,
    input  wire logic       tick_i,
    input  wire logic [8:0] target_i,
    output logic            done_o
);
    import keypad_pkg::*;

    typedef struct packed {
        logic [8:0] count;
    } timer_s;

    timer_s q;
    timer_s d;

    // saturates so a stalled phase never wraps back to zero
    always_comb
    begin
        d = q;
        if (restart_i)
        begin
            d.count = 9'h000;
        end
        else if (tick_i && q.count != 9'h1ff)
        begin
            d.count = q.count + 9'h001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            q <= '{count: 9'h000};
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    assign done_o = (q.count >= target_i);

endmodule

// *** hdl/keypad_scanner.sv ***
// Implementation choice: register access over APB.
module keypad_scanner (
    input  wire logic                             clk_i,
    input  wire logic                             reset_i,
    input  wire logic                             ce_i,
    input  wire logic                             tick_i,
    input  wire logic [keypad_pkg::NUM_ROWS-1:0]  row_i,
    output logic      [keypad_pkg::NUM_COLS-1:0]  col_o,
    output logic                                  key_irq_o,
    output logic                                  slow_osc_sel_o,
    input  wire logic                             psel_i,
    input  wire logic                             penable_i,
    input  wire logic                             pwrite_i,
    input  wire logic [keypad_pkg::ADDR_W-1:0]    paddr_i,
    input  wire logic [31:0]                      pwdata_i,
    output logic      [31:0]                      prdata_o,
    output logic                                  pready_o,
    output logic                                  pslverr_o
);
    import keypad_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        scan_state_e         st;
        logic [2:0]          slot;
        logic [2:0]          row;
        logic [1:0]          hits;
        logic [2:0]          hit_col;
        logic [2:0]          hit_row;
        logic [4:0]          drive_line_register;
        logic [5:0]          sense_line_register;
        logic [7:0]          timing;
        logic [2:0]          keypad_status_control_register;
        logic [7:0]          ord_lo;
        logic [8:0]          ord_hi;
        logic [7:0]          keypad_size_register;
        logic [7:0]          clkctl;
        logic [4:0]          col_out;
        logic                irq;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } scan_s;

    localparam scan_s STATE_RST = '{
        st:      ST_IDLE,
        slot:    3'h0,
        row:     3'h0,
        hits:    2'h0,
        hit_col: 3'h0,
        hit_row: 3'h0,
        drive_line_register:    DRIVE_RST,
        sense_line_register:    SENSE_RST,
        timing:  TIMING_RST,
        keypad_status_control_register:   STATUS_RST,
        ord_lo:  ORDER_LO_RST,
        ord_hi:  ORDER_HI_RST,
        keypad_size_register:   SIZE_RST,
        clkctl:  CLKCTL_RST,
        col_out: DRIVE_RST,
        irq:     1'b0,
        prdata:  32'h0000_0000,
        pready:  1'b0,
        pslverr: 1'b0
    };

    scan_s               q;
    scan_s               d;
    logic [NUM_ROWS-1:0] rows_s;
    logic                tmr_restart;
    logic                tmr_done;
    logic [8:0]          tmr_target;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // out-of-range index drives nothing rather than a wrong column
    function automatic logic [4:0] col_pattern(input logic [2:0] idx);
        logic [4:0] p;
        p = 5'h1f;
        if (idx < 3'(NUM_COLS))
        begin
            p = ~(5'(5'h01 << idx));
        end
        return p;
    endfunction

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    row_sync u_row_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .row_i   (row_i),
        .row_o   (rows_s)
    );

    // 1 ms tick paces every interval
    keypad_timer u_timer (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .restart_i (tmr_restart),
        .tick_i    (tick_i),
        .target_i  (tmr_target),
        .done_o    (tmr_done)
    );

    // ------------------------------------------------------------------
    // timing selection
    // ------------------------------------------------------------------
    logic [6:0] deb_units;
    logic [8:0] deb_ms;
    logic [1:0] scan_time_field;
    logic [8:0] scan_ms;

    always_comb
    begin
        deb_units = {1'b0, q.timing[DEBOUNCE_FIELD_LSB +: 6]};
        if (deb_units == 7'h00)
        begin
            deb_units = DEB_ZERO_UNITS;
        end
        deb_ms  = 9'(deb_units * DEB_UNIT_MS);
        scan_time_field  = q.timing[SCAN_TIME_FIELD_LSB +: 2];
        scan_ms = (scan_time_field == 2'b00) ? SCAN_ZERO_MS : {7'h00, scan_time_field};
        tmr_target = 9'((q.st == ST_SCAN ? scan_ms : deb_ms) / TICK_MS);
    end

    // ------------------------------------------------------------------
    // keypad geometry and order
    // ------------------------------------------------------------------
    logic [2:0]          num_cols;
    logic [2:0]          num_rows;
    logic [NUM_ROWS-1:0] row_mask;
    logic [NUM_COLS-1:0] col_mask;
    logic [14:0]         order;
    logic [2:0]          cur_col;
    logic                any_low;

    always_comb
    begin
        num_cols = q.keypad_size_register[SIZE_COLS_LSB +: 3];
        num_rows = q.keypad_size_register[SIZE_ROWS_LSB +: 3];
        if (num_cols == 3'h0 || num_cols > 3'(NUM_COLS))
        begin
            num_cols = 3'(NUM_COLS);
        end
        if (num_rows == 3'h0 || num_rows > 3'(NUM_ROWS))
        begin
            num_rows = 3'(NUM_ROWS);
        end
        row_mask = 6'(~(6'h3f << num_rows));
        col_mask = 5'(~(5'h1f << num_cols));
        // order registers pick each slot's column
        order    = {q.ord_hi, q.ord_lo[5:0]};
        cur_col  = order[q.slot * SLOT_W +: SLOT_W];
        any_low  = |(~rows_s & row_mask);
    end

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic        setup;
    logic        access;
    logic [7:0]  idx;
    logic        mapped;
    logic [31:0] rd_word;

    always_comb
    begin
        setup   = psel_i & ~penable_i;
        access  = psel_i & penable_i & q.pready;
        idx     = paddr_i[9:2];
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (idx)
            DRIVE_IDX:    rd_word = {27'h0, q.drive_line_register};
            SENSE_IDX:    rd_word = {26'h0, q.sense_line_register};
            TIMING_IDX:   rd_word = {24'h0, q.timing};
            STATUS_IDX:   rd_word = {29'h0, q.keypad_status_control_register};
            ORDER_LO_IDX: rd_word = {24'h0, q.ord_lo};
            ORDER_HI_IDX: rd_word = {23'h0, q.ord_hi};
            SIZE_IDX:     rd_word = {24'h0, q.keypad_size_register};
            CLKCTL_IDX:   rd_word = {24'h0, q.clkctl};
            default:      mapped  = 1'b0;
        endcase
        if (paddr_i[1:0] != 2'b00 || paddr_i[11:10] != 2'b00)
        begin
            mapped  = 1'b0;
            rd_word = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic       wr;
    logic       scan_en;
    logic       set_flag;
    logic [1:0] new_hits;
    logic       row_hit;

    always_comb
    begin
        d           = q;
        tmr_restart = 1'b0;
        set_flag    = 1'b0;
        new_hits    = q.hits;
        row_hit     = 1'b0;
        wr          = access & pwrite_i & mapped;
        scan_en     = q.keypad_status_control_register[ST_SCEN_BIT];

        // one wait-free answer, data captured in the setup cycle
        d.pready  = setup;
        d.pslverr = setup & ~mapped;
        d.prdata  = setup ? rd_word : 32'h0000_0000;

        if (wr)
        begin
            unique case (idx)
                DRIVE_IDX:
                begin
                    if (!scan_en)
                    begin
                        d.drive_line_register = pwdata_i[4:0];
                    end
                end
                TIMING_IDX:   d.timing = pwdata_i[7:0];
                STATUS_IDX:
                begin
                    d.keypad_status_control_register[ST_IEN_BIT]  = pwdata_i[ST_IEN_BIT];
                    d.keypad_status_control_register[ST_SCEN_BIT] = pwdata_i[ST_SCEN_BIT];
                    if (pwdata_i[ST_FLAG_BIT])
                    begin
                        d.keypad_status_control_register[ST_FLAG_BIT] = 1'b0;
                    end
                end
                ORDER_LO_IDX: d.ord_lo = pwdata_i[7:0];
                ORDER_HI_IDX: d.ord_hi = pwdata_i[8:0];
                SIZE_IDX:     d.keypad_size_register  = pwdata_i[7:0];
                CLKCTL_IDX:   d.clkctl = pwdata_i[7:0];
                default:      d.keypad_size_register  = q.keypad_size_register;
            endcase
        end

        if (!scan_en)
        begin
            d.st      = ST_IDLE;
            d.col_out = q.drive_line_register;
            // row bits map one to one
            d.sense_line_register    = rows_s;
        end
        // frozen while keypad enable is low
        else if (q.clkctl[CLK_KEYPAD_ENABLE_BIT])
        begin
            unique case (q.st)
                ST_IDLE:
                begin
                    d.col_out = ~col_mask;
                    if (any_low)
                    begin
                        d.st        = ST_DEB_PRESS;
                        tmr_restart = 1'b1;
                    end
                end
                ST_DEB_PRESS:
                begin
                    d.col_out = ~col_mask;
                    if (tmr_done)
                    begin
                        tmr_restart = 1'b1;
                        d.slot      = 3'h0;
                        d.row       = 3'h0;
                        d.hits      = 2'h0;
                        d.st        = any_low ? ST_SCAN : ST_IDLE;
                    end
                end
                ST_SCAN:
                begin
                    // one column low at a time
                    d.col_out = col_pattern(cur_col);
                    if (tmr_done)
                    begin
                        tmr_restart = 1'b1;
                        row_hit = ~rows_s[q.row] & (cur_col < 3'(NUM_COLS));
                        if (row_hit)
                        begin
                            new_hits  = (q.hits == 2'h2) ? 2'h2 : q.hits + 2'h1;
                            d.hit_col = cur_col;
                            d.hit_row = q.row;
                        end
                        d.hits = new_hits;
                        // rows in fixed order, then next column
                        if (q.row != num_rows - 3'h1)
                        begin
                            d.row = q.row + 3'h1;
                        end
                        else if (q.slot != num_cols - 3'h1)
                        begin
                            d.row  = 3'h0;
                            d.slot = q.slot + 3'h1;
                        end
                        else
                        begin
                            if (new_hits == 2'h1)
                            begin
                                d.drive_line_register   = col_pattern(row_hit ? cur_col : q.hit_col);
                                d.sense_line_register   = ~(6'(6'h01 << (row_hit ? q.row : q.hit_row)));
                                set_flag = 1'b1;
                            end
                            d.st      = ST_WAIT_REL;
                            d.col_out = ~col_mask;
                        end
                    end
                end
                ST_WAIT_REL:
                begin
                    d.col_out = ~col_mask;
                    if (!any_low)
                    begin
                        d.st        = ST_DEB_REL;
                        tmr_restart = 1'b1;
                    end
                end
                ST_DEB_REL:
                begin
                    d.col_out = ~col_mask;
                    if (tmr_done)
                    begin
                        tmr_restart = 1'b1;
                        if (!any_low)
                        begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    d.st = ST_IDLE;
                end
            endcase
        end

        if (set_flag)
        begin
            d.keypad_status_control_register[ST_FLAG_BIT] = 1'b1;
        end
        d.irq = d.keypad_status_control_register[ST_FLAG_BIT] & d.keypad_status_control_register[ST_IEN_BIT];
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            q <= STATE_RST;
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    // drive bits straight onto the pins
    assign col_o          = q.col_out;
    assign key_irq_o      = q.irq;
    assign slow_osc_sel_o = q.clkctl[CLK_SLOW_BIT];
    assign prdata_o       = q.prdata;
    assign pready_o       = q.pready;
    assign pslverr_o      = q.pslverr;

endmodule

// *** verification/keypad_scanner_properties.sv ***
module keypad_scanner_properties (
    input wire logic                          clk_i,
    input wire logic                          reset_i,
    input wire logic                          ce_i,
    input wire logic                          psel_i,
    input wire logic                          penable_i,
    input wire logic                          pwrite_i,
    input wire logic [keypad_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0]                   prdata_o,
    input wire logic                          pready_o,
    input wire logic                          pslverr_o,
    input wire logic [keypad_pkg::NUM_COLS-1:0] col_o,
    input wire logic                          key_irq_o
);
    import keypad_pkg::*;
    // ----------------------------------------
    // bus and keypad checks
    // ----------------------------------------
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    reset_out_a: assert property (disable iff (1'b0)
        reset_i && ce_i |=> col_o == DRIVE_RST && !key_irq_o && !pready_o)
        else $error("outputs not at reset values");
    ready_setup_a: assert property (ce_i && psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    ready_access_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    unmapped_err_a: assert property (pready_o && paddr_i == 12'h364 |-> pslverr_o)
        else $error("unmapped access not refused");
    // flag only drops on a status write, never by itself
    irq_sticky_a: assert property ($fell(key_irq_o) |->
        $past(psel_i && penable_i && pwrite_i && paddr_i == {STATUS_IDX, 2'b00}))
        else $error("key interrupt dropped alone");

    cover property ($rose(key_irq_o));
    cover property (pslverr_o);
    cover property (col_o == 5'h17);
endmodule

bind keypad_scanner keypad_scanner_properties i_props (.clk_i(clk_i), .reset_i(reset_i),
    .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .col_o(col_o), .key_irq_o(key_irq_o));

// *** verification/keypad_matrix.sv ***
module keypad_matrix (
    input  wire logic [keypad_pkg::NUM_COLS-1:0]  col_i,
    input  wire logic [29:0]                      pressed_i,
    output logic      [keypad_pkg::NUM_ROWS-1:0]  row_o
);
    import keypad_pkg::*;
    // ----------------------------------------
    // switch matrix, rows pulled up
    // ----------------------------------------
    always_comb
    begin
        row_o = '1;
        for (int c = 0; c < NUM_COLS; c++)
            for (int r = 0; r < NUM_ROWS; r++)
                if (pressed_i[c*6+r] && !col_i[c])
                    row_o[r] = 1'b0;
    end
endmodule

// *** verification/matrix_keypad_scanner_test.sv ***
module test_matrix_keypad_scanner;
    timeunit 1ns;
    timeprecision 1ns;
    import keypad_pkg::*;
    logic        clk_i, reset_i, ce_i, tick_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic        pready_o, pslverr_o, key_irq_o, slow_osc_sel_o;
    logic [4:0]  col_o;
    logic [5:0]  row_i;
    logic [29:0] pressed;
    int          n_fail, total_checks;
    int          tcnt = 0;

    keypad_scanner i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .tick_i(tick_i),
        .row_i(row_i), .col_o(col_o), .key_irq_o(key_irq_o),
        .slow_osc_sel_o(slow_osc_sel_o), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o));
    keypad_matrix i_keys (.col_i(col_o), .pressed_i(pressed), .row_o(row_i));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // fast tick keeps the run short
    always @(posedge clk_i)
    begin
        tcnt <= (tcnt + 1) % 8;
        tick_i <= (tcnt == 0);
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end while (pready_o !== 1'b1 && i < 20);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
        if (i == 20)
        begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0, r, e);
        check(r, exp);
    endtask
    task automatic wait_irq();
        int i;
        for (i = 0; i < 3000 && key_irq_o !== 1'b1; i++)
            @(posedge clk_i);
        if (i == 3000)
        begin
            n_fail++;
            conclude();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0]  ix [8] = '{DRIVE_IDX, SENSE_IDX, TIMING_IDX, STATUS_IDX,
                               ORDER_LO_IDX, ORDER_HI_IDX, SIZE_IDX, CLKCTL_IDX};
        logic [31:0] rv [8] = '{32'h1f, 32'h3f, 32'h0, 32'h0, 32'h08, 32'h11a, 32'h65, 32'h0};
        logic [31:0] r;
        logic        e;
        check(32'(col_o), 32'h1f);
        for (int k = 0; k < 8; k++)
            rd(ix[k], rv[k]);
        wr(SENSE_IDX, 32'h0);
        rd(SENSE_IDX, 32'h3f);
        apb(1'b0, 8'hd9, 32'h0, r, e);
        check({r[30:0], e}, 32'h1);
    endtask
    task automatic t_bypass();
        wr(DRIVE_IDX, 32'h1e);
        pressed <= 30'h4;
        cyc(3);
        check(32'(col_o), 32'h1e);
        rd(SENSE_IDX, 32'h3b);
        wr(DRIVE_IDX, 32'h0f);
        cyc(3);
        check(32'(col_o), 32'h0f);
        rd(SENSE_IDX, 32'h3f);
        pressed <= '0;
    endtask
    task automatic t_scan();
        wr(TIMING_IDX, 32'h05);
        wr(CLKCTL_IDX, 32'h40);
        wr(STATUS_IDX, 32'h05);
        cyc(3);
        check(32'(col_o), 32'h0);
        pressed <= 30'h1 << 20;
        cyc(20);
        check(32'(col_o), 32'h0);
        wait_irq();
        rd(DRIVE_IDX, 32'h17);
        rd(SENSE_IDX, 32'h3b);
        check(32'(key_irq_o), 32'h1);
        pressed <= '0;
        wr(STATUS_IDX, 32'h07);
        check(32'(key_irq_o), 32'h0);
        cyc(100);
    endtask
    task automatic t_multi();
        pressed <= 30'h1 << 6 | 30'h1 << 29;
        cyc(1500);
        check(32'(key_irq_o), 32'h0);
        wr(DRIVE_IDX, 32'h1e);
        rd(DRIVE_IDX, 32'h17);
        rd(SENSE_IDX, 32'h3b);
        rd(STATUS_IDX, 32'h05);
        pressed <= '0;
        cyc(200);
    endtask
    task automatic t_stop();
        pressed <= 30'h1;
        cyc(100);
        wr(STATUS_IDX, 32'h01);
        cyc(3);
        check(32'(col_o), 32'h17);
        pressed <= '0;
    endtask
    // order skips column 1 first, then covers it; size cut to 3 columns
    task automatic t_order();
        wr(CLKCTL_IDX, 32'h08);
        wr(SIZE_IDX, 32'h63);
        wr(ORDER_LO_IDX, 32'h00);
        wr(ORDER_HI_IDX, 32'h02);
        wr(STATUS_IDX, 32'h05);
        cyc(3);
        check(32'(slow_osc_sel_o), 32'h1);
        check(32'(col_o), 32'h17);
        wr(CLKCTL_IDX, 32'h40);
        cyc(3);
        check(32'(col_o), 32'h18);
        pressed <= 30'h1 << 10;
        cyc(600);
        check(32'(key_irq_o), 32'h0);
        wr(ORDER_HI_IDX, 32'h01);
        pressed <= '0;
        cyc(100);
        wr(TIMING_IDX, 32'h00);
        pressed <= 30'h1 << 10;
        cyc(1500);
        check(32'(key_irq_o), 32'h0);
        wait_irq();
        rd(DRIVE_IDX, 32'h1d);
        rd(SENSE_IDX, 32'h2f);
        pressed <= '0;
    endtask

    initial
    begin
        {reset_i, ce_i} = 2'b11;
        {psel_i, penable_i, pwrite_i} = '0;
        paddr_i = '0;
        pwdata_i = '0;
        pressed = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_bypass();
        t_scan();
        t_multi();
        t_stop();
        t_order();
        conclude();
    end
endmodule
